// ==== src/rkp_pkg.sv ====
package rkp_pkg;

  // clock and slow tick
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;

  // key store layout: one entry per key button (channel)
  localparam int KEY_SLOTS = 25;
  localparam int SLOT_W = 5;
  localparam int CODE_W = 28;
  localparam int CHAN_W = 2;
  localparam int ENTRY_W = CODE_W + CHAN_W;
  localparam logic [SLOT_W-1:0] LAST_SLOT = 5'h18;
  localparam logic [CHAN_W-1:0] MASTER_CHAN = 2'h1;

  // documented times in milliseconds
  localparam int SHORT_PRESS_MS = 1000;
  localparam int LONG_PRESS_MS = 3000;
  localparam int STEP_TIMEOUT_MS = 20000;
  localparam int ACK_MS = 2000;
  localparam int DONE_GREEN_MS = 1000;
  localparam int DONE_RED_MS = 4000;
  localparam int SLOW_HALF_MS = 500;
  localparam int FAST_HALF_MS = 100;

  // the same times as tick counts
  localparam int TMR_W = 12;
  localparam logic [TMR_W-1:0] T_SHORT = TMR_W'((SHORT_PRESS_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [TMR_W-1:0] T_LONG = TMR_W'((LONG_PRESS_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [TMR_W-1:0] T_STEP = TMR_W'(STEP_TIMEOUT_MS / TICK_MS);
  localparam logic [TMR_W-1:0] T_ACK = TMR_W'((ACK_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [TMR_W-1:0] T_DONE_G = TMR_W'((DONE_GREEN_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [TMR_W-1:0] T_DONE_R = TMR_W'((DONE_RED_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [TMR_W-1:0] T_SLOW = TMR_W'(SLOW_HALF_MS / TICK_MS);
  localparam logic [TMR_W-1:0] T_FAST = TMR_W'(FAST_HALF_MS / TICK_MS);
  localparam logic [TMR_W-1:0] T_MAX = 12'hfff;

  typedef enum logic [3:0] {
    ST_IDLE, ST_PRESS, ST_L_MASTER, ST_L_ACK, ST_L_KEY1, ST_L_KEY2,
    ST_D_MASTER, ST_D_ACK, ST_D_WAIT, ST_D_HOLD, ST_SCAN_RD, ST_SCAN_CK, ST_SHOW
  } rkp_state_t;

endpackage : rkp_pkg

// ==== src/rkp_tick.sv ====
`timescale 1ns/1ps
module rkp_tick import rkp_pkg::*; #(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, active high
  output logic tick // one-cycle pulse every tick period
);

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic wrap;

  // free-running divider, wraps at the tick period
  assign wrap = (cnt_q == 32'(TICK_CYCLES_P - 1));
  always_comb begin
    cnt_d = wrap ? 32'h0 : cnt_q + 32'h1;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'h0;
      tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick <= wrap;
    end
  end

endmodule : rkp_tick

// ==== src/rkp_keymem.sv ====
`timescale 1ns/1ps
module rkp_keymem import rkp_pkg::*; (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, active high
  input wire logic [SLOT_W-1:0] rdAddr, // slot to read
  output logic [ENTRY_W-1:0] rdData, // registered entry
  output logic rdValid, // registered occupied flag
  input wire logic wrEn, // store wrData into wrAddr
  input wire logic clrEn, // free slot wrAddr
  input wire logic [SLOT_W-1:0] wrAddr, // slot to write or free
  input wire logic [ENTRY_W-1:0] wrData, // channel and code
  input wire logic clrAll // free every user slot
);

  logic [ENTRY_W-1:0] mem [KEY_SLOTS];
  logic [KEY_SLOTS-1:0] used_q;
  logic [KEY_SLOTS-1:0] used_d;

  // one occupied flag per slot; clearing all wins over a write
  for (genvar i = 0; i < KEY_SLOTS; i++) begin : g_slot
    always_comb begin
      used_d[i] = used_q[i];
      if (clrAll) begin
        used_d[i] = 1'b0;
      end else if (wrAddr == SLOT_W'(i)) begin
        if (wrEn) begin
          used_d[i] = 1'b1;
        end else if (clrEn) begin
          used_d[i] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      used_q <= '0;
      rdValid <= 1'b0;
      rdData <= '0;
    end else begin
      used_q <= used_d;
      rdValid <= used_q[rdAddr];
      rdData <= mem[rdAddr];
    end
  end

  // code storage has no reset; the occupied flags guard it
  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

endmodule : rkp_keymem

// ==== src/rkp_ctrl.sv ====
// Summary of operation
// - store up to 25 user key codes beside the master code
// - master middle button code is fixed and never erased or replaced
// - button press of at most 1 s enters learn mode, slow flash
// - learn mode needs master within 20 s, then green 2 s, slow flash
// - new key must arrive twice in a row within 20 s, else abort
// - learned key: control green 1 s, receiver red 4 s
// - button held over 3 s enters delete mode, fast flash
// - delete mode needs master within 20 s, then green 2 s, fast flash
// - stored user key within 20 s is erased, else abort
// - single erase lights green 1 s, then off
// - button hold over 3 s begun within 20 s erases all users
// - full erase: control green 1 s, receiver red 4 s
// - unrecognised master aborts the procedure, codes unchanged
// - every key button is its own entry: channel plus code
`timescale 1ns/1ps
module rkp_ctrl import rkp_pkg::*; #(
  parameter int TICK_CYCLES_P = TICK_CYCLES, // cycles per slow tick
  parameter logic [CODE_W-1:0] MASTER_CODE = 28'h0a1b2c3 // arbitrary value
) (
  input wire logic clk_sys, // system clock, 250 MHz
  input wire logic rst, // async reset, active high
  input wire logic progBtn, // programming button pin, high = pressed
  input wire logic keyValid, // one-cycle pulse, decoded key received
  input wire logic [CODE_W-1:0] keyCode, // decoded key code
  input wire logic [CHAN_W-1:0] keyChan, // button (channel) of the key
  output logic ledGreen, // control unit green LED
  output logic ledRed, // receiver module red LED
  output logic busy // procedure in progress
);

  rkp_state_t state_q, state_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [TMR_W-1:0] flash_q, flash_d;
  logic blink_q, blink_d;
  logic [ENTRY_W-1:0] first_q, first_d;
  logic [SLOT_W-1:0] idx_q, idx_d;
  logic [SLOT_W-1:0] free_q, free_d;
  logic freeOk_q, freeOk_d;
  logic learn_q, learn_d;
  logic showRed_q, showRed_d;
  logic btnMeta_q, btnSync_q, btnPrev_q;
  logic ledGreen_d, ledRed_d;
  logic tick;
  logic tmrClr;
  logic isMaster;
  logic btnRise;
  logic [ENTRY_W-1:0] rxEntry;
  logic [ENTRY_W-1:0] rdData;
  logic rdValid;
  logic wrEn, clrEn, clrAll;
  logic [SLOT_W-1:0] wrAddr;
  logic scanHit;
  logic stepOut;

  rkp_tick #(
    .TICK_CYCLES_P(TICK_CYCLES_P)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(tick)
  );

  rkp_keymem u_mem (
    .clk_sys(clk_sys),
    .rst(rst),
    .rdAddr(idx_q),
    .rdData(rdData),
    .rdValid(rdValid),
    .wrEn(wrEn),
    .clrEn(clrEn),
    .wrAddr(wrAddr),
    .wrData(first_q),
    .clrAll(clrAll)
  );

  // button pin is asynchronous: two flops before any use
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      btnMeta_q <= 1'b0;
      btnSync_q <= 1'b0;
      btnPrev_q <= 1'b0;
    end else begin
      btnMeta_q <= progBtn;
      btnSync_q <= btnMeta_q;
      btnPrev_q <= btnSync_q;
    end
  end

  // received key as a stored entry; channel is part of the identity
  assign rxEntry = {keyChan, keyCode};
  assign isMaster = (keyChan == MASTER_CHAN) && (keyCode == MASTER_CODE);
  assign btnRise = btnSync_q && !btnPrev_q;
  assign scanHit = rdValid && (rdData == first_q);
  assign stepOut = (tmr_q >= T_STEP);

  // flash phase generator, shared by slow and fast flashing
  always_comb begin
    flash_d = flash_q;
    blink_d = blink_q;
    if (tick) begin
      flash_d = flash_q + 12'h1;
      if (flash_q >= ((state_q == ST_D_MASTER || state_q == ST_D_WAIT
                       || state_q == ST_D_HOLD) ? T_FAST - 12'h1 : T_SLOW - 12'h1)) begin
        flash_d = 12'h0;
        blink_d = !blink_q;
      end
    end
  end

  // procedure sequencer
  always_comb begin
    state_d = state_q;
    tmrClr = 1'b0;
    first_d = first_q;
    idx_d = idx_q;
    free_d = free_q;
    freeOk_d = freeOk_q;
    learn_d = learn_q;
    showRed_d = showRed_q;
    wrEn = 1'b0;
    clrEn = 1'b0;
    clrAll = 1'b0;
    wrAddr = idx_q;
    unique case (state_q)
      ST_IDLE: begin
        if (btnRise) begin
          state_d = ST_PRESS;
          tmrClr = 1'b1;
        end
      end
      ST_PRESS: begin
        if (!btnSync_q) begin
          // a release between the two windows means nothing
          state_d = (tmr_q <= T_SHORT) ? ST_L_MASTER : ST_IDLE;
          tmrClr = 1'b1;
        end else if (tmr_q > T_LONG) begin
          state_d = ST_D_MASTER;
          tmrClr = 1'b1;
        end
      end
      ST_L_MASTER, ST_D_MASTER: begin
        if (keyValid) begin
          // any other key at this step is an unrecognised master
          if (isMaster) begin
            state_d = (state_q == ST_L_MASTER) ? ST_L_ACK : ST_D_ACK;
          end else begin
            state_d = ST_IDLE;
          end
          tmrClr = 1'b1;
        end else if (stepOut) begin
          state_d = ST_IDLE;
        end
      end
      ST_L_ACK: begin
        if (tmr_q >= T_ACK) begin
          state_d = ST_L_KEY1;
          tmrClr = 1'b1;
        end
      end
      ST_D_ACK: begin
        if (tmr_q >= T_ACK) begin
          state_d = ST_D_WAIT;
          tmrClr = 1'b1;
        end
      end
      ST_L_KEY1: begin
        if (keyValid) begin
          first_d = rxEntry;
          state_d = isMaster ? ST_IDLE : ST_L_KEY2;
        end else if (stepOut) begin
          state_d = ST_IDLE;
        end
      end
      ST_L_KEY2: begin
        // 20 s counts from the end of the green acknowledge for both presses
        if (keyValid) begin
          if (rxEntry == first_q) begin
            state_d = ST_SCAN_RD;
            learn_d = 1'b1;
            idx_d = '0;
            freeOk_d = 1'b0;
          end else begin
            state_d = ST_IDLE;
          end
        end else if (stepOut) begin
          state_d = ST_IDLE;
        end
      end
      ST_D_WAIT: begin
        if (keyValid) begin
          first_d = rxEntry;
          learn_d = 1'b0;
          idx_d = '0;
          state_d = isMaster ? ST_IDLE : ST_SCAN_RD;
        end else if (btnRise) begin
          state_d = ST_D_HOLD;
          tmrClr = 1'b1;
        end else if (stepOut) begin
          state_d = ST_IDLE;
        end
      end
      ST_D_HOLD: begin
        if (!btnSync_q) begin
          state_d = ST_IDLE;
        end else if (tmr_q > T_LONG) begin
          clrAll = 1'b1;
          showRed_d = 1'b1;
          state_d = ST_SHOW;
          tmrClr = 1'b1;
        end
      end
      ST_SCAN_RD: begin
        // read data is registered, so each slot takes two cycles
        state_d = ST_SCAN_CK;
      end
      ST_SCAN_CK: begin
        if (!rdValid && !freeOk_q) begin
          free_d = idx_q;
          freeOk_d = 1'b1;
        end
        if (scanHit) begin
          // learning a stored key again keeps one entry
          clrEn = !learn_q;
          showRed_d = learn_q;
          state_d = ST_SHOW;
          tmrClr = 1'b1;
        end else if (idx_q != LAST_SLOT) begin
          idx_d = idx_q + 5'h1;
          state_d = ST_SCAN_RD;
        end else if (learn_q && (freeOk_q || !rdValid)) begin
          wrEn = 1'b1;
          wrAddr = freeOk_q ? free_q : idx_q;
          showRed_d = 1'b1;
          state_d = ST_SHOW;
          tmrClr = 1'b1;
        end else begin
          // store full, or unknown key to delete
          state_d = ST_IDLE;
        end
      end
      ST_SHOW: begin
        if (tmr_q >= (showRed_q ? T_DONE_R : T_DONE_G)) begin
          state_d = ST_IDLE;
        end
      end
    endcase
    if (state_d == ST_IDLE) begin
      first_d = '0;
    end
  end

  // step timer counts ticks and saturates
  always_comb begin
    tmr_d = (tick && tmr_q != T_MAX) ? tmr_q + 12'h1 : tmr_q;
    if (tmrClr) begin
      tmr_d = '0;
    end
  end

  // LED pattern per state, registered to keep the pins glitch free
  always_comb begin
    ledGreen_d = 1'b0;
    ledRed_d = 1'b0;
    unique case (state_q)
      ST_L_MASTER, ST_L_KEY1, ST_L_KEY2: begin
        ledGreen_d = blink_q;
        ledRed_d = blink_q;
      end
      ST_D_MASTER, ST_D_WAIT, ST_D_HOLD: begin
        ledGreen_d = blink_q;
        ledRed_d = blink_q;
      end
      ST_L_ACK, ST_D_ACK: begin
        ledGreen_d = 1'b1;
      end
      ST_SHOW: begin
        ledGreen_d = (tmr_q < T_DONE_G);
        ledRed_d = showRed_q && (tmr_q < T_DONE_R);
      end
      default: begin
        ledGreen_d = 1'b0;
        ledRed_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      tmr_q <= '0;
      flash_q <= '0;
      blink_q <= 1'b0;
      first_q <= '0;
      idx_q <= '0;
      free_q <= '0;
      freeOk_q <= 1'b0;
      learn_q <= 1'b0;
      showRed_q <= 1'b0;
      ledGreen <= 1'b0;
      ledRed <= 1'b0;
      busy <= 1'b0;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      flash_q <= flash_d;
      blink_q <= blink_d;
      first_q <= first_d;
      idx_q <= idx_d;
      free_q <= free_d;
      freeOk_q <= freeOk_d;
      learn_q <= learn_d;
      showRed_q <= showRed_d;
      ledGreen <= ledGreen_d;
      ledRed <= ledRed_d;
      busy <= (state_d != ST_IDLE);
    end
  end

endmodule : rkp_ctrl

// ==== tb/rkp_ctrl_monitor.sv ====
`timescale 1ns/1ps
module rkp_ctrl_monitor import rkp_pkg::*; #(
  parameter int TICK_CYCLES_P = TICK_CYCLES,
  parameter logic [CODE_W-1:0] MASTER_CODE = 28'h0a1b2c3 // arbitrary value
) (
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic progBtn, // button pin
  input wire logic keyValid, // key strobe
  input wire logic [CODE_W-1:0] keyCode, // key code
  input wire logic [CHAN_W-1:0] keyChan, // key channel
  input wire logic ledGreen, // green LED
  input wire logic ledRed, // red LED
  input wire logic busy // in procedure
);
  // a lit run may merge with one flash half-period, hence the slack
  localparam int GMAX = 251 * TICK_CYCLES_P + 4;
  localparam int RMAX = 451 * TICK_CYCLES_P + 4;
  localparam int QMAX = 2201 * TICK_CYCLES_P + 60;
  logic keySeen_q, keySeen_d, isMaster;
  int gRun_q, gRun_d, rRun_q, rRun_d, quiet_q, quiet_d;
  // first key of a procedure is the master check
  always_comb begin
    isMaster = keyCode == MASTER_CODE && keyChan == MASTER_CHAN;
    keySeen_d = busy && (keySeen_q || keyValid);
    gRun_d = ledGreen ? gRun_q + 1 : 0;
    rRun_d = ledRed ? rRun_q + 1 : 0;
    quiet_d = (!busy || keyValid || progBtn) ? 0 : quiet_q + 1;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      keySeen_q <= 1'b0;
      gRun_q <= 0;
      rRun_q <= 0;
      quiet_q <= 0;
    end else begin
      keySeen_q <= keySeen_d;
      gRun_q <= gRun_d;
      rRun_q <= rRun_d;
      quiet_q <= quiet_d;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence masterHit;
    busy && !keySeen_q && keyValid && isMaster;
  endsequence
  sequence strangerHit;
    busy && !keySeen_q && keyValid && !isMaster;
  endsequence
  sequence ackShow;
    (ledGreen && !ledRed) [*8];
  endsequence
  rst_quiet_a: assert property ($fell(rst) |-> !busy && !ledGreen && !ledRed)
    else $error("outputs not clear after reset");
  idle_key_a: assert property ((!progBtn) [*6] ##0 (!busy && keyValid) |=> !busy)
    else $error("key started a procedure");
  busy_rise_a: assert property ($rose(busy) |-> $past(progBtn, 3))
    else $error("busy without button");
  master_ack_a: assert property (masterHit |=> ##1 ackShow)
    else $error("master not acknowledged");
  wrong_master_a: assert property (strangerHit |=> ##1 !busy && !ledGreen && !ledRed)
    else $error("wrong master not aborted");
  green_run_a: assert property (ledGreen |-> gRun_q < GMAX)
    else $error("green lit too long");
  red_run_a: assert property (ledRed |-> rRun_q < RMAX)
    else $error("red lit too long");
  step_limit_a: assert property (busy |-> quiet_q < QMAX)
    else $error("step timeout missed");
  idle_dark_a: assert property ((!busy) [*3] |-> !ledGreen && !ledRed)
    else $error("LED lit while idle");
endmodule : rkp_ctrl_monitor

bind rkp_ctrl rkp_ctrl_monitor #(.TICK_CYCLES_P(TICK_CYCLES_P), .MASTER_CODE(MASTER_CODE)) i_mon (
  .clk_sys(clk_sys), .rst(rst), .progBtn(progBtn), .keyValid(keyValid), .keyCode(keyCode),
  .keyChan(keyChan), .ledGreen(ledGreen), .ledRed(ledRed), .busy(busy));

// ==== tb/rkp_radio_model.sv ====
`timescale 1ns/1ps
module rkp_radio_model import rkp_pkg::*; (
  input wire logic clk_sys, // system clock
  output logic keyValid, // decoded key strobe
  output logic [CODE_W-1:0] keyCode, // decoded code
  output logic [CHAN_W-1:0] keyChan // key button
);
  // quiet receiver at power up
  initial begin
    keyValid = 1'b0;
    keyCode = '0;
    keyChan = '0;
  end
  // one-cycle strobe; data inverted after so stale values never look valid
  task automatic send(input logic [CODE_W-1:0] c, input logic [CHAN_W-1:0] ch);
    @(negedge clk_sys);
    keyValid = 1'b1;
    keyCode = c;
    keyChan = ch;
    @(negedge clk_sys);
    keyValid = 1'b0;
    keyCode = ~c;
    keyChan = ~ch;
  endtask : send
endmodule : rkp_radio_model

// ==== tb/radio_key_pairing_controller_tb.sv ====
`timescale 1ns/1ps
module radio_key_pairing_controller_tb import rkp_pkg::*;;
  localparam logic [CODE_W-1:0] MKEY = 28'h0a1b2c3; // arbitrary value
  typedef struct {int t0; int dt; int gap;} rkp_note_t;
  logic clk_sys = 1'b0, rst = 1'b1, progBtn = 1'b0;
  logic keyValid, ledGreen, ledRed, busy, prevG = 1'b0, prevB = 1'b0, prevR = 1'b0;
  logic [CODE_W-1:0] keyCode, base;
  logic [CHAN_W-1:0] keyChan;
  int failures = 0, testsRun = 0, cyc = 0, tGf = 0, tRf = 0, tRr = 0;
  rkp_note_t q[$];

  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc++;

  // short tick so second-scale times fit the run: one tick is 2 cycles
  rkp_ctrl #(.TICK_CYCLES_P(2), .MASTER_CODE(MKEY)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .progBtn(progBtn), .keyValid(keyValid), .keyCode(keyCode),
    .keyChan(keyChan), .ledGreen(ledGreen), .ledRed(ledRed), .busy(busy));
  rkp_radio_model i_radio (.clk_sys(clk_sys), .keyValid(keyValid), .keyCode(keyCode),
    .keyChan(keyChan));

  task automatic conclude();
    // a procedure that never ended leaves its note behind
    if (q.size() != 0) begin
      failures++;
      $display("ERROR %0t %0d expected procedure ends never seen", $time, q.size());
    end
    $display("checks %0d, errors %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  // end of a procedure: compare its timing with the oldest note
  task automatic check();
    rkp_note_t n;
    int dt;
    testsRun++;
    if (q.size() == 0) begin
      failures++;
      $display("ERROR %0t unexpected end of procedure", $time);
      return;
    end
    n = q.pop_front();
    dt = cyc - n.t0;
    if (dt < n.dt - 4 || dt > n.dt + 70) begin
      failures++;
      $display("ERROR %0t ended after %0d cycles, expected %0d", $time, dt, n.dt);
    end
    if (n.gap >= 0 && (cyc - tGf < n.gap - 6 || cyc - tGf > n.gap + 6)) begin
      failures++;
      $display("ERROR %0t green off %0d before end, expected %0d", $time, cyc - tGf, n.gap);
    end
    // red must cover the whole 4 s show after a learn or a full erase
    if (n.gap > 0 && (cyc - tRf > 6 || cyc - tRr < 794 || cyc - tRr > 826)) begin
      failures++;
      $display("ERROR %0t red lit %0d, off %0d before end, expected 800 and 0", $time,
        cyc - tRr, cyc - tRf);
    end
    // a single erase shows green only
    if (n.gap == 0 && cyc - tRf < 150) begin
      failures++;
      $display("ERROR %0t red lit after a single erase", $time);
    end
  endtask : check

  // watcher, settled values at the falling edge
  always @(negedge clk_sys) begin
    if (prevG === 1'b1 && ledGreen === 1'b0) tGf = cyc;
    if (prevR === 1'b0 && ledRed === 1'b1) tRr = cyc;
    if (prevR === 1'b1 && ledRed === 1'b0) tRf = cyc;
    if (prevB === 1'b1 && busy === 1'b0 && rst === 1'b0) check();
    prevG = ledGreen;
    prevB = busy;
    prevR = ledRed;
  end

  task automatic note(int dt, int gap);
    q.push_back('{cyc, dt, gap});
  endtask : note

  task automatic press(int n);
    @(negedge clk_sys);
    progBtn = 1'b1;
    repeat (n) @(negedge clk_sys);
    progBtn = 1'b0;
  endtask : press

  task automatic waitIdle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 6000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 6000) begin
      failures++;
      $display("ERROR %0t busy stuck", $time);
      conclude();
    end else repeat (4) @(negedge clk_sys);
  endtask : waitIdle

  // hold 20 cycles for learn, 620 (over 300 ticks) for delete
  task automatic modeMaster(int hold);
    press(hold);
    repeat (10) @(negedge clk_sys);
    i_radio.send(MKEY, MASTER_CHAN);
    repeat (420) @(negedge clk_sys);
  endtask : modeMaster

  // kind 0 learned, 1 aborted at first key, 2 aborted at second key
  task automatic learn(logic [CODE_W-1:0] c, logic [CHAN_W-1:0] ch, logic [CODE_W-1:0] c2,
    int kind);
    modeMaster(20);
    if (kind == 1) note(0, -1);
    i_radio.send(c, ch);
    repeat (5) @(negedge clk_sys);
    if (kind != 1) note(kind == 0 ? 800 : 0, kind == 0 ? 600 : -1);
    i_radio.send(c2, ch);
    waitIdle();
  endtask : learn

  task automatic delKey(logic [CODE_W-1:0] c, logic [CHAN_W-1:0] ch, bit ok);
    modeMaster(620);
    note(ok ? 200 : 0, ok ? 0 : -1);
    i_radio.send(c, ch);
    waitIdle();
  endtask : delKey

  // step timeouts: before the master or after its acknowledge
  task automatic timeoutRun(int hold, bit m);
    press(hold);
    if (!m) note(4000, -1);
    else begin
      repeat (10) @(negedge clk_sys);
      note(4400, -1);
      i_radio.send(MKEY, MASTER_CHAN);
    end
    waitIdle();
  endtask : timeoutRun

  task automatic badMaster(int hold);
    press(hold);
    repeat (10) @(negedge clk_sys);
    note(0, -1);
    i_radio.send(base, 2'h0);
    waitIdle();
  endtask : badMaster

  initial begin
    void'($urandom(32'h39fe));
    base = CODE_W'($urandom()) | 28'h8000000;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    timeoutRun(20, 1'b0);
    timeoutRun(20, 1'b1);
    timeoutRun(620, 1'b1);
    badMaster(20);
    badMaster(620);
    learn(base, 2'h0, base, 0);
    learn(base, 2'h0, base, 0);
    learn(base, CHAN_W'($urandom()) | 2'h2, base, 0);
    learn(base + 28'h1, 2'h3, base + 28'h2, 2);
    learn(MKEY, MASTER_CHAN, MKEY, 1);
    delKey(MKEY, MASTER_CHAN, 1'b0);
    delKey(base, 2'h0, 1'b1);
    delKey(base, 2'h0, 1'b0);
    // a hold released before 3 s erases nothing
    modeMaster(620);
    note(100, -1);
    press(100);
    waitIdle();
    modeMaster(620);
    note(1400, 600);
    press(620);
    waitIdle();
    for (int i = 0; i < 25; i++) learn(base + CODE_W'(i + 4), CHAN_W'(i), base + CODE_W'(i + 4), 0);
    learn(base + 28'h40, 2'h0, base + 28'h40, 2);
    delKey(base + 28'h4, 2'h0, 1'b1);
    modeMaster(620);
    note(1400, 600);
    press(620);
    waitIdle();
    delKey(base + 28'h5, 2'h1, 1'b0);
    conclude();
  end
endmodule : radio_key_pairing_controller_tb
